//--- common/pin_cfg_pkg.sv
// package: register map, field layout and pin function codes
package pin_cfg_pkg;
    localparam int          REG_ADDR_W        = 8;
    localparam int          WORD_LSB          = 2;
    localparam int          UNITS_W           = 5;
    localparam logic [7:0]  PIN_SETTING_OFS   = 8'h00;
    localparam logic [7:0]  UNITS_SETTING_OFS = 8'h04;
    localparam logic [7:0]  PIN_CONTROL_OFS   = 8'h08;
    localparam logic [7:0]  PIN_STATUS_OFS    = 8'h0c;
    localparam logic [7:0]  PIN_SETTING_RST   = 8'h00;
    localparam logic [4:0]  UNITS_SETTING_RST = 5'h05;
    // pin setting fields
    localparam int          FXN_MSB           = 1;
    localparam int          FXN_LSB           = 0;
    localparam int          OPT_MSB           = 7;
    localparam int          OPT_LSB           = 2;
    // option bits, relative to the option field
    localparam int          OPT_POLARITY      = 5;
    localparam int          OPT_HI_SUPPLY     = 3;
    localparam int          OPT_PULL_UP       = 2;
    localparam int          OPT_DRIVE_HI      = 1;
    localparam int          OPT_PULL_DOWN     = 0;
    localparam int          ANA_PU_MSB        = 5;
    localparam int          ANA_PU_LSB        = 4;
    localparam int          ANA_MODEL_MSB     = 3;
    localparam int          ANA_MODEL_LSB     = 2;
    localparam int          ANA_USE_MSB       = 1;
    localparam int          ANA_USE_LSB       = 0;
    localparam logic [1:0]  PU_LOW            = 2'h0;
    localparam logic [1:0]  PU_HIGH           = 2'h1;
    // units setting fields
    localparam int          AMPS_MSB          = 1;
    localparam int          AMPS_LSB          = 0;
    localparam int          VOLTS_BIT         = 2;
    localparam int          CELL_T_BIT        = 3;
    localparam int          FET_T_BIT         = 4;
    // control and status fields
    localparam int          CTRL_GPO_LEVEL    = 0;
    localparam int          STAT_OUT          = 0;
    localparam int          STAT_OE           = 1;
    localparam int          STAT_FN_LSB       = 2;
    localparam int          STAT_DISABLED     = 4;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef enum logic [1:0] {
        FN_UNUSED,
        FN_GPO,
        FN_INDICATOR,
        FN_ANALOG
    } pin_function_e;

    function automatic logic word_match(input logic [REG_ADDR_W-1:0] addr,
                                        input logic [REG_ADDR_W-1:0] ofs);
        return addr[REG_ADDR_W-1:WORD_LSB] == ofs[REG_ADDR_W-1:WORD_LSB];
    endfunction : word_match
endpackage : pin_cfg_pkg

//--- common/pin_cfg_if.sv
// interface: settings into the option decoder and decoded pin controls out
`timescale 1ns/1ps
interface pin_cfg_if import pin_cfg_pkg::*; ();
    logic [7:0]         pin_setting;
    logic [UNITS_W-1:0] units_setting;
    logic               gpo_level;
    logic               discharge_path_disabled;
    pin_function_e      func;
    logic               pin_out;
    logic               pin_oe;
    logic               high_supply_sel;
    logic               weak_pull_up_en;
    logic               weak_pull_down_en;
    logic               therm_pullup_low_en;
    logic               therm_pullup_high_en;
    logic [1:0]         temp_model;
    logic [1:0]         meas_use;
    logic [1:0]         current_unit;
    logic               voltage_unit_10mv;
    logic               internal_sensor_as_cell_temp;
    logic               internal_sensor_as_transistor_temp;

    modport regs (output pin_setting, units_setting, gpo_level, discharge_path_disabled,
                  input  func, pin_out, pin_oe, high_supply_sel, weak_pull_up_en,
                         weak_pull_down_en, therm_pullup_low_en, therm_pullup_high_en,
                         temp_model, meas_use, current_unit, voltage_unit_10mv,
                         internal_sensor_as_cell_temp, internal_sensor_as_transistor_temp);
    modport decode (input  pin_setting, units_setting, gpo_level, discharge_path_disabled,
                    output func, pin_out, pin_oe, high_supply_sel, weak_pull_up_en,
                           weak_pull_down_en, therm_pullup_low_en, therm_pullup_high_en,
                           temp_model, meas_use, current_unit, voltage_unit_10mv,
                           internal_sensor_as_cell_temp, internal_sensor_as_transistor_temp);
endinterface : pin_cfg_if

//--- src/pin_option_decode.sv
// module: decodes the pin and units settings into registered pin controls
`timescale 1ns/1ps
module pin_option_decode import pin_cfg_pkg::*; (
    // clock and reset
    input  wire logic   aclk,
    input  wire logic   aresetn,
    // settings in, controls out
    pin_cfg_if.decode   c
);
    wire [5:0]     pin_option_bits      = c.pin_setting[OPT_MSB:OPT_LSB];
    // function select
    // function field
    wire pin_function_e fn  = pin_function_e'(c.pin_setting[FXN_MSB:FXN_LSB]);
    wire           out_fn   = (fn == FN_GPO) || (fn == FN_INDICATOR);
    wire           ana_fn   = (fn == FN_ANALOG);
    // indicator polarity, output function ignores it
    wire           level    = (fn == FN_INDICATOR)
                              ? (c.discharge_path_disabled ^ pin_option_bits[OPT_POLARITY])
                              : c.gpo_level;
    // high level floats unless driven high or high supply chosen
    wire           drive_hi = pin_option_bits[OPT_DRIVE_HI] | pin_option_bits[OPT_HI_SUPPLY];
    wire           next_oe  = out_fn && (!level || drive_hi);
    wire           next_out = out_fn && level;
    wire [1:0]     pu_sel   = pin_option_bits[ANA_PU_MSB:ANA_PU_LSB];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c.func                  <= FN_UNUSED;
            c.pin_out               <= 1'b0;
            c.pin_oe                <= 1'b0;
            c.high_supply_sel       <= 1'b0;
            c.weak_pull_up_en       <= 1'b0;
            c.weak_pull_down_en     <= 1'b0;
            c.therm_pullup_low_en   <= 1'b0;
            c.therm_pullup_high_en  <= 1'b0;
            c.temp_model            <= 2'h0;
            c.meas_use              <= 2'h0;
        end else begin
            c.func                  <= fn;
            c.pin_out               <= next_out;
            c.pin_oe                <= next_oe;
            c.high_supply_sel       <= out_fn && pin_option_bits[OPT_HI_SUPPLY];
            c.weak_pull_up_en       <= out_fn && pin_option_bits[OPT_PULL_UP];
            c.weak_pull_down_en     <= out_fn && pin_option_bits[OPT_PULL_DOWN];
            c.therm_pullup_low_en   <= ana_fn && (pu_sel == PU_LOW);
            c.therm_pullup_high_en  <= ana_fn && (pu_sel == PU_HIGH);
            c.temp_model            <= ana_fn ? pin_option_bits[ANA_MODEL_MSB:ANA_MODEL_LSB] : 2'h0;
            c.meas_use              <= ana_fn ? pin_option_bits[ANA_USE_MSB:ANA_USE_LSB] : 2'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c.current_unit                       <= UNITS_SETTING_RST[AMPS_MSB:AMPS_LSB];
            c.voltage_unit_10mv                  <= UNITS_SETTING_RST[VOLTS_BIT];
            c.internal_sensor_as_cell_temp       <= UNITS_SETTING_RST[CELL_T_BIT];
            c.internal_sensor_as_transistor_temp <= 1'b0;
        end else begin
            c.current_unit                       <= c.units_setting[AMPS_MSB:AMPS_LSB];
            c.voltage_unit_10mv                  <= c.units_setting[VOLTS_BIT];
            c.internal_sensor_as_cell_temp       <= c.units_setting[CELL_T_BIT];
            c.internal_sensor_as_transistor_temp <= c.units_setting[FET_T_BIT]
                                                    && c.units_setting[CELL_T_BIT];
        end
    end

    unused_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (fn == FN_UNUSED) |=> !c.pin_oe && !c.weak_pull_up_en && !c.therm_pullup_low_en)
        else $error("unused pin still driven or pulled");
endmodule : pin_option_decode

//--- src/multifunction_pin_config.sv
// module: register slave and pin controls for one multifunction pin
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module multifunction_pin_config import pin_cfg_pkg::*; #(
    parameter int ADDR_W = REG_ADDR_W
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address channel
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // write data channel
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read address channel
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // read data channel
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // protection state
    input  wire logic              discharge_path_disabled,
    // pin drive
    output logic                   pin_out,
    output logic                   pin_oe,
    output logic                   high_supply_sel,
    output logic                   weak_pull_up_en,
    output logic                   weak_pull_down_en,
    // analog front end
    output logic                   therm_pullup_low_en,
    output logic                   therm_pullup_high_en,
    output logic [1:0]             temp_model,
    output logic [1:0]             meas_use,
    // reporting units and internal sensor
    output logic [1:0]             current_unit,
    output logic                   voltage_unit_10mv,
    output logic                   internal_sensor_as_cell_temp,
    output logic                   internal_sensor_as_transistor_temp
);
    pin_cfg_if cfg ();

    logic [7:0]         pin_setting;
    logic [UNITS_W-1:0] units_setting;
    logic               gpo_level;
    logic               aw_held;
    logic               w_held;
    logic [ADDR_W-1:0]  aw_addr_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;

    // write channel acceptance, either order
    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    wire               aw_take  = awvalid && awready;
    wire               w_take   = wvalid && wready;
    wire               wr_go    = (aw_held || aw_take) && (w_held || w_take) && !bvalid;
    wire [ADDR_W-1:0]  wr_addr  = aw_held ? aw_addr_q : awaddr;
    wire [31:0]        wr_data  = w_held ? w_data_q : wdata;
    wire [3:0]         wr_strb  = w_held ? w_strb_q : wstrb;

    // address decode
    wire wr_pin    = word_match(wr_addr, PIN_SETTING_OFS);
    wire wr_units  = word_match(wr_addr, UNITS_SETTING_OFS);
    wire wr_ctrl   = word_match(wr_addr, PIN_CONTROL_OFS);
    wire wr_status = word_match(wr_addr, PIN_STATUS_OFS);
    wire wr_mapped = wr_pin || wr_units || wr_ctrl || wr_status;
    wire wr_lane0  = wr_go && wr_strb[0];

    wire rd_take   = arvalid && arready;
    wire rd_pin    = word_match(araddr, PIN_SETTING_OFS);
    wire rd_units  = word_match(araddr, UNITS_SETTING_OFS);
    wire rd_ctrl   = word_match(araddr, PIN_CONTROL_OFS);
    wire rd_status = word_match(araddr, PIN_STATUS_OFS);
    wire rd_mapped = rd_pin || rd_units || rd_ctrl || rd_status;

    // status word shows live pin state
    wire [31:0] status_word = {27'h0, discharge_path_disabled, cfg.func, pin_oe, pin_out};
    wire [31:0] rd_word = rd_pin    ? {24'h0, pin_setting}
                        : rd_units  ? {27'h0, units_setting}
                        : rd_ctrl   ? {31'h0, gpo_level}
                        : rd_status ? status_word
                        : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
        end else begin
            aw_held   <= !wr_go && (aw_held || aw_take);
            w_held    <= !wr_go && (w_held || w_take);
            if (aw_take) begin
                aw_addr_q <= awaddr;
            end
            if (w_take) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read answer
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // settings registers, byte lane 0 only; status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_setting   <= PIN_SETTING_RST;
            units_setting <= UNITS_SETTING_RST;
            gpo_level     <= 1'b0;
        end else if (wr_lane0) begin
            if (wr_pin) begin
                pin_setting <= wr_data[7:0];
            end
            if (wr_units) begin
                units_setting <= wr_data[UNITS_W-1:0];
            end
            if (wr_ctrl) begin
                gpo_level <= wr_data[CTRL_GPO_LEVEL];
            end
        end
    end

    assign cfg.pin_setting             = pin_setting;
    assign cfg.units_setting           = units_setting;
    assign cfg.gpo_level               = gpo_level;
    assign cfg.discharge_path_disabled = discharge_path_disabled;

    pin_option_decode u_decode (
        .aclk    (aclk),
        .aresetn (aresetn),
        .c       (cfg.decode)
    );

    assign pin_out                            = cfg.pin_out;
    assign pin_oe                             = cfg.pin_oe;
    assign high_supply_sel                    = cfg.high_supply_sel;
    assign weak_pull_up_en                    = cfg.weak_pull_up_en;
    assign weak_pull_down_en                  = cfg.weak_pull_down_en;
    assign therm_pullup_low_en                = cfg.therm_pullup_low_en;
    assign therm_pullup_high_en               = cfg.therm_pullup_high_en;
    assign temp_model                         = cfg.temp_model;
    assign meas_use                           = cfg.meas_use;
    assign current_unit                       = cfg.current_unit;
    assign voltage_unit_10mv                  = cfg.voltage_unit_10mv;
    assign internal_sensor_as_cell_temp       = cfg.internal_sensor_as_cell_temp;
    assign internal_sensor_as_transistor_temp = cfg.internal_sensor_as_transistor_temp;

    // checks on bus handshakes, decoded pin controls and reporting units
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire [5:0]         opt_now = pin_setting[OPT_MSB:OPT_LSB];
    wire pin_function_e fn_now = pin_function_e'(pin_setting[FXN_MSB:FXN_LSB]);
    wire               out_now = (fn_now == FN_GPO) || (fn_now == FN_INDICATOR);
    wire               ana_now = (fn_now == FN_ANALOG);

    sequence pin_write_s;
        wr_lane0 && wr_pin;
    endsequence
    sequence pin_updated_s;
        pin_setting == $past(wr_data[7:0]) ##1 cfg.func == $past(fn_now);
    endsequence

    pin_write_a: assert property (pin_write_s |=> pin_updated_s)
        else $error("pin setting write not applied");

    write_answer_a: assert property (wr_go |=> bvalid
        && bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR))
        else $error("write response missing");

    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    sequence read_take_s;
        rd_take && !rd_mapped;
    endsequence
    read_unmapped_a: assert property (read_take_s |=> rvalid && rresp == RESP_SLVERR)
        else $error("unmapped read not refused");

    ind_high_a: assert property (
        fn_now == FN_INDICATOR && !opt_now[OPT_POLARITY] && discharge_path_disabled
        |=> pin_out)
        else $error("active-high indicator not high");

    ind_low_a: assert property (
        fn_now == FN_INDICATOR && opt_now[OPT_POLARITY] && discharge_path_disabled
        |=> !pin_out && pin_oe)
        else $error("active-low indicator not driven low");

    gpo_polarity_a: assert property (
        fn_now == FN_GPO |=> pin_out == $past(gpo_level))
        else $error("output function affected by polarity");

    supply_sel_a: assert property (
        out_now |=> high_supply_sel == $past(opt_now[OPT_HI_SUPPLY]))
        else $error("high drive supply wrong");

    pull_up_a: assert property (
        out_now |=> weak_pull_up_en == $past(opt_now[OPT_PULL_UP]))
        else $error("weak pull-up wrong");

    tristate_hi_a: assert property (
        out_now && !opt_now[OPT_DRIVE_HI] && !opt_now[OPT_HI_SUPPLY]
        && fn_now == FN_GPO && gpo_level |=> !pin_oe)
        else $error("pin driven instead of floating");

    pull_down_a: assert property (
        out_now |=> weak_pull_down_en == $past(opt_now[OPT_PULL_DOWN]))
        else $error("weak pull-down wrong");

    therm_pullup_a: assert property (
        ana_now |=> !pin_oe
        && therm_pullup_low_en == ($past(opt_now[ANA_PU_MSB:ANA_PU_LSB]) == PU_LOW)
        && therm_pullup_high_en == ($past(opt_now[ANA_PU_MSB:ANA_PU_LSB]) == PU_HIGH))
        else $error("thermistor pull-up wrong");

    model_use_a: assert property (
        ana_now |=> temp_model == $past(opt_now[ANA_MODEL_MSB:ANA_MODEL_LSB]))
        else $error("temperature model wrong");

    meas_use_a: assert property (
        ana_now |=> meas_use == $past(opt_now[ANA_USE_MSB:ANA_USE_LSB]))
        else $error("measurement use wrong");

    option_split_a: assert property (
        !out_now |=> !high_supply_sel && !weak_pull_down_en)
        else $error("output options leak into other function");

    fet_temp_a: assert property (
        !units_setting[CELL_T_BIT] |=> !internal_sensor_as_transistor_temp)
        else $error("transistor temp used without cell temp");

    units_a: assert property (
        1'b1 |=> current_unit == $past(units_setting[AMPS_MSB:AMPS_LSB]))
        else $error("current unit wrong");

    volts_a: assert property (
        1'b1 |=> voltage_unit_10mv == $past(units_setting[VOLTS_BIT]))
        else $error("voltage unit wrong");
endmodule : multifunction_pin_config

//--- testbench/pin_load_model.sv
// model of the pin load: driven level, weak pulls, or a floating line
`timescale 1ns/1ps
module pin_load_model (
    // clock
    input  wire logic aclk,
    // pin controls from the device
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic weak_pull_up_en,
    input  wire logic weak_pull_down_en,
    // level seen on the wire
    output logic      pin_level
);
    logic float_q = 1'b0;
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end
    assign pin_level = pin_oe ? pin_out :
                       weak_pull_up_en ? 1'b1 : weak_pull_down_en ? 1'b0 : float_q;
endmodule : pin_load_model

//--- testbench/multifunction_pin_config_tb_top.sv
// testbench: register access and pin decode checks
`timescale 1ns/1ps
module multifunction_pin_config_tb_top import pin_cfg_pkg::*; ;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, discharge_path_disabled = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0]  wstrb = 0;
    logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_level;
    logic        high_supply_sel, weak_pull_up_en, weak_pull_down_en, therm_pullup_low_en;
    logic        therm_pullup_high_en, voltage_unit_10mv, internal_sensor_as_cell_temp;
    logic        internal_sensor_as_transistor_temp;
    logic [1:0]  bresp, rresp, temp_model, meas_use, current_unit, r;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    wire logic [10:0] pins = {pin_oe, pin_out, high_supply_sel, weak_pull_up_en,
        weak_pull_down_en, therm_pullup_low_en, therm_pullup_high_en, temp_model, meas_use};
    wire logic [4:0]  units_out = {current_unit, voltage_unit_10mv,
        internal_sensor_as_cell_temp, internal_sensor_as_transistor_temp};

    multifunction_pin_config multifunction_pin_config_inst (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .discharge_path_disabled, .pin_out, .pin_oe, .high_supply_sel, .weak_pull_up_en,
        .weak_pull_down_en, .therm_pullup_low_en, .therm_pullup_high_en, .temp_model,
        .meas_use, .current_unit, .voltage_unit_10mv, .internal_sensor_as_cell_temp,
        .internal_sensor_as_transistor_temp);
    pin_load_model pin_load_model_inst (.aclk, .pin_out, .pin_oe, .weak_pull_up_en,
        .weak_pull_down_en, .pin_level);

    initial forever #50 aclk = ~aclk;

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            r = rresp;
            d = rdata;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic pin_case(input logic [7:0] s, input logic l, input logic dis,
                            input logic [10:0] e);
        wr(PIN_SETTING_OFS, {24'h0, s});
        wr(PIN_CONTROL_OFS, {31'h0, l});
        discharge_path_disabled <= dis;
        repeat (3) @(posedge aclk);
        chk(32'(pins), 32'(e));
        if (e[10] | e[7] | e[6]) chk(32'(pin_level), 32'(e[10] ? e[9] : e[7]));
    endtask : pin_case

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(units_out), 32'h0c);
        rd(UNITS_SETTING_OFS);
        chk(d, 32'(UNITS_SETTING_RST));
        wr(PIN_SETTING_OFS, 32'h1, 4'h0);
        rd(PIN_SETTING_OFS);
        chk(d, 32'(PIN_SETTING_RST));
        wr(8'h10, 32'h1);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(8'h10);
        chk(32'(r), 32'(RESP_SLVERR));
        chk(d, 32'h0);
        pin_case(8'h01, 1'b0, 1'b0, 11'h400);
        pin_case(8'h09, 1'b1, 1'b0, 11'h600);
        pin_case(8'h01, 1'b1, 1'b0, 11'h200);
        pin_case(8'h21, 1'b1, 1'b0, 11'h700);
        pin_case(8'h89, 1'b1, 1'b1, 11'h600);
        pin_case(8'h0a, 1'b0, 1'b1, 11'h600);
        rd(PIN_STATUS_OFS);
        chk(d, 32'h1b);
        rd(PIN_SETTING_OFS);
        chk(d, 32'h0a);
        pin_case(8'h0a, 1'b1, 1'b0, 11'h400);
        pin_case(8'h8a, 1'b0, 1'b1, 11'h400);
        pin_case(8'h8a, 1'b0, 1'b0, 11'h600);
        pin_case(8'h11, 1'b1, 1'b0, 11'h280);
        pin_case(8'h05, 1'b1, 1'b0, 11'h240);
        pin_case(8'hfc, 1'b1, 1'b1, 11'h000);
        for (int i = 0; i < 64; i++) begin
            pin_case({i[5:0], 2'b11}, 1'b1, 1'b1,
                     {5'h0, i[5:4] == 2'b00, i[5:4] == 2'b01, i[3:0]});
        end
        for (int i = 0; i < 32; i++) begin
            wr(UNITS_SETTING_OFS, 32'(i));
            repeat (2) @(posedge aclk);
            chk(32'(units_out), 32'({i[1:0], i[2], i[3], i[4] & i[3]}));
            rd(UNITS_SETTING_OFS);
            chk(d, 32'(i));
        end
        summarize();
    end
endmodule : multifunction_pin_config_tb_top
